/* core/rss_pkg.sv */
// Purpose: Shared constants and types of the start-up sequencer.
// Assumes: A 50 MHz system clock.
// Notes:   Cycle counts derive from the times and the clock rate.
package rss_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  // Least assertion time of the external reset, in microseconds.
  localparam int unsigned T_RST_MIN_US    = 5;
  localparam int unsigned RST_MIN_CYC     = T_RST_MIN_US * CYC_PER_US;
  // Least strap hold time, in milliseconds.
  localparam int unsigned T_CSH_MS        = 1;
  localparam int unsigned CSH_CYC         = T_CSH_MS * CYC_PER_MS;
  // Longest reset-to-ready time, in milliseconds.
  localparam int unsigned T_RDY_MAX_MS    = 250;
  localparam int unsigned RDY_MAX_CYC     = T_RDY_MAX_MS * CYC_PER_MS;
  // Attach-to-ready window, in milliseconds.
  localparam int unsigned T_ATT_MIN_MS    = 30;
  localparam int unsigned T_ATT_MAX_MS    = 65;
  localparam int unsigned ATT_MIN_CYC     = T_ATT_MIN_MS * CYC_PER_MS;
  localparam int unsigned ATT_MAX_CYC     = T_ATT_MAX_MS * CYC_PER_MS;
  // Configuration load time after the straps are taken, in milliseconds.
  localparam int unsigned T_CFG_MS        = 2;
  localparam int unsigned CFG_CYC         = T_CFG_MS * CYC_PER_MS;
  // Standard-mode two-wire rate.
  localparam int unsigned I2C_HZ          = 100_000;
  localparam int unsigned I2C_DIV         = CLK_HZ / I2C_HZ;
  // Reference clock tolerance in parts per million.
  localparam int unsigned REF_PPM         = 350;
  localparam logic [15:0] ATTACH_CMD      = 16'haa55;
  localparam int unsigned OTP_PAGES       = 4;

  typedef enum logic [2:0] {
    ST_HOLD, ST_STRAP, ST_CFG, ST_READY, ST_ATTACH, ST_RUN
  } rss_state_t;
endpackage

/* core/rss_tmr_if.sv */
// Purpose: Carrier between the sequencer and its interval timer.
// Assumes: One clock domain.
// Notes:   A load pulse starts a count; done marks its final cycle.
`timescale 1ns/1ps
interface rss_tmr_if #(parameter int unsigned CW = 32);
  logic          load;
  logic [CW-1:0] count;
  logic          done;
  logic          busy;
  modport ctrl  (output load, output count, input done, input busy);
  modport timer (input load, input count, output done, output busy);
endinterface // rss_tmr_if

/* core/rss_timer.sv */
// Purpose: Down-counting interval timer.
// Assumes: A load of N makes done high in the N-th cycle after the load edge.
// Notes:   A new load restarts the count at once.
`timescale 1ns/1ps
module rss_timer #(
  parameter int unsigned CW = 32
) (
  input  wire logic  mclk,
  input  wire logic  rst,
  rss_tmr_if.timer   tmr
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  assign tmr.busy = (cnt_q != '0);
  assign tmr.done = (cnt_q == CW'(1));
  assign cnt_d    = tmr.load ? tmr.count : (tmr.busy ? cnt_q - CW'(1) : cnt_q);

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  property p_done_once;
    @(posedge mclk) disable iff (rst) tmr.done && !tmr.load |=> !tmr.busy;
  endproperty
  a_done_once: assert property (p_done_once) else $error("timer did not stop after done");
endmodule // rss_timer

/* core/rss_top.sv */
// Purpose: Start-up sequencer: straps, client readiness, attach, clocks.
// Assumes: All inputs synchronous to mclk; rst stands for power-on reset.
// Notes:   The client answers addressed transfers only while ready.
`timescale 1ns/1ps
module rss_top
  import rss_pkg::*;
#(
  parameter int unsigned CW          = 32,
  parameter int unsigned STRAP_W     = 4,
  parameter int unsigned STRAP_CYC   = CSH_CYC,
  parameter int unsigned LOAD_CYC    = CFG_CYC,
  parameter int unsigned ATT_LO_CYC  = ATT_MIN_CYC,
  parameter int unsigned ATT_HI_CYC  = ATT_MAX_CYC,
  parameter int unsigned READY_CYC   = RDY_MAX_CYC
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               ext_reset_n,
  input  wire logic [STRAP_W-1:0] strap_in,
  input  wire logic [2:0]         otp_pages_used,
  input  wire logic               cmd_valid,
  input  wire logic [15:0]        cmd_code,
  input  wire logic               addr_match,
  input  wire logic               usb_suspend,
  input  wire logic               clk_force_on,
  input  wire logic               ref_mode,
  input  wire logic               ref_clock_in,
  input  wire logic               crystal_in,
  output logic                    crystal_out,
  output logic                    crystal_out_oe,
  output logic                    osc_out,
  output logic [STRAP_W-1:0]      strap_val,
  output logic                    smb_ready,
  output logic                    smb_ack,
  output logic                    cmd_ack,
  output logic                    hub_attached,
  output logic                    i2c_tick
);
  // ==========================================================================
  // Elaboration checks
  // Readiness shows one cycle after the release edge plus both intervals.
  if (STRAP_CYC == 0 || LOAD_CYC == 0 || STRAP_CYC + LOAD_CYC + 1 > READY_CYC) begin : g_chk_rdy
    $error("strap hold plus load exceeds the ready bound");
  end
  if (ATT_LO_CYC == 0 || ATT_LO_CYC > ATT_HI_CYC || ATT_HI_CYC >= 2**(CW-4)) begin : g_chk_att
    $error("attach window not servable");
  end

  // ==========================================================================
  // Sequencer
  rss_tmr_if #(.CW(CW)) tmr ();
  rss_timer #(.CW(CW)) u_timer (.mclk(mclk), .rst(rst), .tmr(tmr));

  rss_state_t         state_q;
  rss_state_t         state_d;
  logic [STRAP_W-1:0] strap_q;
  logic               cmd_ack_q;
  logic [CW-1:0]      att_cyc;
  logic [CW-1:0]      att_span;
  logic [2:0]         otp_eff;
  logic               seq_rst;
  logic               start_strap;
  logic               start_cfg;
  logic               cmd_take;
  logic               clk_gated;

  assign seq_rst     = rst | ~ext_reset_n;
  assign start_strap = (state_q == ST_HOLD);
  assign start_cfg   = (state_q == ST_STRAP) && tmr.done;
  assign clk_gated   = usb_suspend && !clk_force_on;
  assign cmd_take    = cmd_valid && (cmd_code == ATTACH_CMD) && (state_q == ST_READY)
                       && !clk_gated;
  // The attach delay grows with the amount of programmed OTP.
  assign att_span    = CW'(ATT_HI_CYC - ATT_LO_CYC);
  // Page counts above the fitted pages are clamped so the delay stays in its window.
  assign otp_eff     = (otp_pages_used > 3'(OTP_PAGES)) ? 3'(OTP_PAGES) : otp_pages_used;
  assign att_cyc     = CW'(ATT_LO_CYC) + CW'((att_span * CW'(otp_eff)) / OTP_PAGES);

  assign tmr.load    = start_strap | start_cfg | cmd_take;
  assign tmr.count   = start_strap ? CW'(STRAP_CYC) :
                       start_cfg   ? CW'(LOAD_CYC)  :
                                     att_cyc;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD:   state_d = ST_STRAP;
      ST_STRAP:  if (tmr.done) begin
                   state_d = ST_CFG;
                 end
      ST_CFG:    if (tmr.done) begin
                   state_d = ST_READY;
                 end
      ST_READY:  if (cmd_take) begin
                   state_d = ST_ATTACH;
                 end
      ST_ATTACH: if (tmr.done) begin
                   state_d = ST_RUN;
                 end
      ST_RUN:    state_d = ST_RUN;
      default:   state_d = ST_HOLD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (seq_rst) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Straps are taken when each hold interval ends and kept until the next hold end or rst; ext_reset_n does not clear them.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_q <= '0;
    end else if (start_cfg) begin
      strap_q <= strap_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (seq_rst) begin
      cmd_ack_q <= 1'b0;
    end else begin
      cmd_ack_q <= cmd_take;
    end
  end

  assign strap_val    = strap_q;
  assign cmd_ack      = cmd_ack_q;
  assign hub_attached = (state_q == ST_RUN);
  assign smb_ready    = ((state_q == ST_READY) || (state_q == ST_RUN)) && !clk_gated;
  assign smb_ack      = addr_match && smb_ready;

  // ==========================================================================
  // Clock source and standard-mode rate
  logic        osc_q;
  logic [15:0] div_q;
  logic        tick_q;
  logic        div_end;

  assign div_end        = (div_q == 16'(I2C_DIV - 1));
  assign crystal_out    = ~crystal_in;
  assign crystal_out_oe = !ref_mode;
  assign osc_out        = osc_q;
  assign i2c_tick       = tick_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= ref_mode ? ref_clock_in : crystal_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_end ? '0 : div_q + 16'h0001;
      tick_q <= div_end;
    end
  end

  // ==========================================================================
  // Checks
  logic [CW-1:0] phase_q;
  logic [CW-1:0] rdy_cnt_q;
  logic          seen_rdy_q;

  always_ff @(posedge mclk) begin
    if (seq_rst || state_q != state_d) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (seq_rst) begin
      rdy_cnt_q  <= '0;
      seen_rdy_q <= 1'b0;
    end else if (!seen_rdy_q) begin
      rdy_cnt_q  <= rdy_cnt_q + CW'(1);
      seen_rdy_q <= (state_q == ST_READY);
    end
  end

  property p_ready_bound;
    @(posedge mclk) disable iff (seq_rst) !seen_rdy_q |-> rdy_cnt_q <= CW'(READY_CYC);
  endproperty
  a_ready_bound: assert property (p_ready_bound) else $error("ready too late");

  property p_strap_hold;
    @(posedge mclk) disable iff (seq_rst)
      (state_q == ST_STRAP) && tmr.done |-> phase_q == CW'(STRAP_CYC - 1);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap hold wrong");

  property p_strap_kept;
    @(posedge mclk) disable iff (seq_rst)
      (state_q == ST_READY) && $past(state_q == ST_READY) |-> $stable(strap_val);
  endproperty
  a_strap_kept: assert property (p_strap_kept) else $error("straps changed");

  property p_att_window;
    @(posedge mclk) disable iff (seq_rst)
      (state_q == ST_ATTACH) && tmr.done |->
        (phase_q + CW'(1) >= CW'(ATT_LO_CYC)) && (phase_q + CW'(1) <= CW'(ATT_HI_CYC));
  endproperty
  a_att_window: assert property (p_att_window) else $error("attach delay out of window");

  property p_att_ack;
    @(posedge mclk) disable iff (seq_rst)
      cmd_take |=> cmd_ack && (state_q == ST_ATTACH) && !smb_ready;
  endproperty
  a_att_ack: assert property (p_att_ack) else $error("attach not taken");

  property p_no_early_ack;
    @(posedge mclk) disable iff (seq_rst)
      !(state_q inside {ST_READY, ST_RUN}) |-> !smb_ack;
  endproperty
  a_no_early_ack: assert property (p_no_early_ack) else $error("early acknowledge");

  property p_suspend_gate;
    @(posedge mclk) disable iff (seq_rst) usb_suspend && !clk_force_on |-> !smb_ack;
  endproperty
  a_suspend_gate: assert property (p_suspend_gate) else $error("reachable in suspend");

  property p_i2c_rate;
    @(posedge mclk) disable iff (rst) i2c_tick |=> !i2c_tick [*8];
  endproperty
  a_i2c_rate: assert property (p_i2c_rate) else $error("two-wire tick too fast");

  property p_xtal_open;
    @(posedge mclk) disable iff (rst) ref_mode |-> !crystal_out_oe;
  endproperty
  a_xtal_open: assert property (p_xtal_open) else $error("crystal output driven");

  c_ready:   cover property (@(posedge mclk) disable iff (seq_rst) $rose(smb_ready));
  c_attach:  cover property (@(posedge mclk) disable iff (seq_rst) $rose(hub_attached));
  c_suspend: cover property (@(posedge mclk) disable iff (seq_rst)
                             hub_attached && usb_suspend && clk_force_on && smb_ack);
endmodule // rss_top

/* verif/rss_host_model.sv */
// Purpose: Host and board reset model on the far side of the sequencer.
// Assumes: Requests change just after the falling edge of mclk.
// Notes:   A released command bus shows the inverse of its last code.
`timescale 1ns/1ps
module rss_host_model (
  input  wire logic        mclk,
  output logic             ext_reset_n,
  output logic             addr_match,
  output logic             cmd_valid,
  output logic [15:0]      cmd_code
);
  initial begin
    ext_reset_n = 1'b1;
    addr_match  = 1'b0;
    cmd_valid   = 1'b0;
    cmd_code    = 16'h0000;
  end
  // ==========================================================
  // Requests
  task automatic board_reset(input int lo_cyc);
    @(negedge mclk);
    ext_reset_n = 1'b0;
    repeat (lo_cyc) @(negedge mclk);
    ext_reset_n = 1'b1;
  endtask
  // The caller keeps the bus idle until readiness returns.
  task automatic send_cmd(input logic [15:0] code);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code  = code;
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
  endtask
  task automatic probe(input int n);
    @(negedge mclk);
    addr_match = 1'b1;
    repeat (n) @(negedge mclk);
    addr_match = 1'b0;
  endtask
endmodule // rss_host_model

/* verif/rss_top_bench.sv */
// Purpose: Self-checking bench of the start-up sequencer.
// Assumes: Short interval parameters; expected figures derive from them.
// Notes:   A monitor pops each expected ready latency when smb_ready rises.
`timescale 1ns/1ps
module rss_top_bench;
  import rss_pkg::*;
  localparam int S = 20, L = 30, AL = 40, AH = 80, RC = 200;
  logic mclk = 1'b0, rst = 1'b1, usb_suspend = 1'b0, clk_force_on = 1'b0;
  logic ref_mode = 1'b0, ref_clock_in = 1'b0, crystal_in = 1'b0;
  logic [3:0] strap_in = 4'h0;
  logic [2:0] otp_pages_used = 3'h0;
  logic ext_reset_n, cmd_valid, addr_match, crystal_out, crystal_out_oe, osc_out;
  logic smb_ready, smb_ack, cmd_ack, hub_attached, i2c_tick, prev_rdy, prev_sel, arm;
  logic [15:0] cmd_code;
  logic [3:0] strap_val;
  int seed = 27, error_cnt = 0, check_count = 0, cyc = 0, cnt = 0, acks = 0, last_tick = 0;
  int exp_q[$];
  always #10 mclk = ~mclk;
  rss_host_model i_rss_host_model (.mclk(mclk), .ext_reset_n(ext_reset_n),
    .addr_match(addr_match), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
  rss_top #(.STRAP_CYC(S), .LOAD_CYC(L), .ATT_LO_CYC(AL), .ATT_HI_CYC(AH),
    .READY_CYC(RC)) i_rss_top (.mclk(mclk), .rst(rst), .ext_reset_n(ext_reset_n),
    .strap_in(strap_in), .otp_pages_used(otp_pages_used), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .addr_match(addr_match), .usb_suspend(usb_suspend),
    .clk_force_on(clk_force_on), .ref_mode(ref_mode), .ref_clock_in(ref_clock_in),
    .crystal_in(crystal_in), .crystal_out(crystal_out), .crystal_out_oe(crystal_out_oe),
    .osc_out(osc_out), .strap_val(strap_val), .smb_ready(smb_ready), .smb_ack(smb_ack),
    .cmd_ack(cmd_ack), .hub_attached(hub_attached), .i2c_tick(i2c_tick));
  // ==========================================================
  // Reporting
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // ==========================================================
  // Monitor
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      test_done();
    end
    if (!rst && prev_rdy !== 1'b1 && smb_ready === 1'b1) begin
      if (exp_q.size() == 0) cmp(1'b0, "unexpected ready");
      else cmp(cnt == exp_q.pop_front(), "ready latency");
    end
    cmp(smb_ack === (addr_match & smb_ready), "ack while not ready");
    cmp(crystal_out === ~crystal_in && crystal_out_oe === ~ref_mode, "osc pins");
    if (arm) cmp(osc_out === prev_sel, "osc select");
    if (i2c_tick === 1'b1) begin
      if (last_tick != 0) cmp(cyc - last_tick == I2C_DIV, "tick period");
      last_tick = cyc;
    end
    if (cmd_ack === 1'b1) acks++;
    // Attach latency counts from the accepting edge, the acknowledge cycle being the first.
    if (rst || !ext_reset_n) cnt = 0;
    else if (cmd_ack === 1'b1) cnt = 1;
    else cnt++;
    prev_rdy = smb_ready;
    prev_sel = ref_mode ? ref_clock_in : crystal_in;
    arm = !rst;
  end
  always @(negedge mclk) begin
    crystal_in <= 1'($random(seed));
    ref_clock_in <= 1'($random(seed));
  end
  // ==========================================================
  // Scenarios
  task automatic wait_ready;
    int n;
    n = 0;
    while (smb_ready !== 1'b1 && n < RC + 10) begin
      @(negedge mclk);
      n++;
    end
    cmp(smb_ready === 1'b1, "ready timeout");
  endtask
  task automatic check_ready_after_reset(input logic [3:0] s);
    // The release edge, the strap hold and the configuration load.
    exp_q.push_back(S + L + 1);
    fork
      i_rss_host_model.probe(S + 5);
    join_none
    wait_ready();
    cmp(strap_val === s, "strap value");
  endtask
  initial begin
    arm = 1'b0;
    prev_rdy = 1'b0;
    strap_in = 4'($random(seed));
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    check_ready_after_reset(strap_in);
    i_rss_host_model.send_cmd(16'h1234);
    repeat (3) @(negedge mclk);
    cmp(acks == 0 && smb_ready === 1'b1, "wrong code taken");
    for (int k = 0; k <= 4; k++) begin
      if (k > 0) begin
        strap_in = 4'($random(seed));
        ref_mode = k[0];
        i_rss_host_model.board_reset(RST_MIN_CYC);
        check_ready_after_reset(strap_in);
      end
      otp_pages_used = 3'(k);
      exp_q.push_back(AL + (AH - AL) * k / 4);
      i_rss_host_model.send_cmd(ATTACH_CMD);
      @(negedge mclk);
      cmp(acks == k + 1, "attach not acknowledged");
      cmp(smb_ready === 1'b0, "ready during attach");
      wait_ready();
      cmp(hub_attached === 1'b1, "not attached");
    end
    i_rss_host_model.send_cmd(ATTACH_CMD);
    repeat (2) @(negedge mclk);
    cmp(acks == 5, "second attach taken");
    usb_suspend = 1'b1;
    fork
      i_rss_host_model.probe(4);
    join_none
    @(negedge mclk);
    cmp(smb_ready === 1'b0, "reachable in suspend");
    clk_force_on = 1'b1;
    // Readiness returns in the very cycle that the clocks are forced on.
    exp_q.push_back(cnt);
    @(negedge mclk);
    cmp(smb_ready === 1'b1, "clock forcing ignored");
    repeat (1100) @(negedge mclk);
    test_done();
  end
endmodule // rss_top_bench
